/* File: hdl/mrs_framer.sv */
/*
 Serial-line slave framer: reply FIFO and the framer top.
 Assumes a byte UART beside it, inputs synchronous to ref_clk_i, one clock.
*/
// Contract
// RULE1 - One master, up to 247 slaves; the slave never transmits unasked.
// RULE2 - A reply is sent only for an accepted request from the master.
// RULE3 - Frame is address, function code, data bytes, two check bytes.
// RULE4 - The reply starts with the slave's own station address.
// RULE5 - Address 0 is broadcast: accepted by all, never answered.
// RULE6 - Second byte is the function code choosing the service.
// RULE7 - Data length and format follow the function code.
// RULE8 - The 16-bit check value goes low byte first, then high byte.
// RULE9 - Frames are delimited only by 3.5 character times of silence.
// RULE10 - After the gap the next byte is the address of a new frame.
// RULE11 - Gap elapsing after received bytes completes the frame for checking.
// RULE12 - An overlong gap inside a frame drops it and starts a new one.
// RULE13 - Above 19200 bit/s the gap stays at the 19200 bit/s value.
// RULE14 - Gap is 32.083, 16.042, 8.021, 4.010 ms at 1200..9600 bit/s.
// RULE15 - Function codes 01 and 02 are supported.
// RULE16 - Function codes 03 and 04 are supported.
// RULE17 - Function codes 05 and 06 are supported.
// RULE18 - Function codes 15 and 16 are supported.
// RULE19 - Function code 43, device identification, is supported.
// RULE20 - Reply starts after at least the gap, at most one scan cycle.
// RULE21 - Only binary framing is used; no character-coded mode.
// RULE22 - Address is configurable on the multidrop port, fixed 1 point-to-point.
// RULE23 - Rate setting 0..6 means 1200..57600 bit/s; default setting 4.
// RULE24 - Address 1..247 applies in slave mode only; ignored as master.
// RULE25 - Check value is CRC-16, reflected poly a001, start ffff.
// RULE26 - Bad check value or foreign address: discard silently, no reply.
`timescale 1ns/1ps
`default_nettype none

module mrs_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } mrs_fifo_st_t;

   mrs_fifo_st_t s_q, s_d;
   logic         push, pop;

   assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (s_q.cnt != '0);
   assign out_data_o  = s_q.mem[s_q.rd];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data_i;
         s_d.wr          = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush_i) begin
         s_d.wr  = '0;
         s_d.rd  = '0;
         s_d.cnt = '0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

module mrs_framer
   import mrs_pkg::*;
#(
   parameter int unsigned GAP_CYC [5] = '{GAP_CYC_1200, GAP_CYC_2400, GAP_CYC_4800,
                                          GAP_CYC_9600, GAP_CYC_19200},
   parameter int unsigned TMO_CYC     = REPLY_TMO_CYC,
   parameter int unsigned DEPTH       = FIFO_DEPTH
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic [2:0]   baud_sel_i,
   input  wire logic [7:0]   slave_addr_i,
   input  wire logic         p2p_port_i,
   input  wire logic         master_mode_i,
   input  wire logic         rx_valid_i,
   input  wire logic [7:0]   rx_data_i,
   input  wire logic         rx_err_i,
   output logic              out_valid_o,
   output logic [7:0]        out_data_o,
   output logic              out_first_o,
   output logic              frame_done_o,
   output mrs_pkg::mrs_verdict_t verdict_o,
   input  wire logic         reply_valid_i,
   input  wire mrs_pkg::mrs_byte_t reply_data_i,
   output logic              reply_ready_o,
   output logic              reply_drop_o,
   output logic              tx_valid_o,
   output logic [7:0]        tx_data_o,
   input  wire logic         tx_ready_i,
   output logic              tx_busy_o
);
   import mrs_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] idle;
      logic             in_frame;
      logic [7:0]       nbytes;
      logic [7:0]       addr;
      logic [7:0]       func;
      logic [15:0]      rx_crc;
      logic             err;
      logic             out_valid;
      logic [7:0]       out_data;
      logic             out_first;
      logic             done;
      mrs_verdict_t     verdict;
      logic             pend;
      mrs_tx_st_t       st;
      logic [CNT_W-1:0] tmo;
      logic [15:0]      tx_crc;
      logic             tx_valid;
      logic [7:0]       tx_data;
      logic             drop;
   } mrs_st_t;

   mrs_st_t          s_q, s_d;
   logic [CNT_W-1:0] gap_cyc;
   logic [2:0]       sel;
   logic [7:0]       own_addr;
   logic             gap_hit, load, fifo_in_rdy, fifo_v, fifo_pop, flush;
   mrs_byte_t        fifo_out;

   // Out-of-range settings fall back to the default rate
   assign sel = (baud_sel_i > BAUD_SEL_MAX) ? BAUD_SEL_DEFAULT : baud_sel_i; // [RULE23]
   // Faster rates share the 19200 bit/s gap [RULE13] [RULE14]
   assign gap_cyc = CNT_W'((sel >= BAUD_SEL_FLOOR) ? GAP_CYC[BAUD_SEL_FLOOR] : GAP_CYC[sel]);
   assign own_addr = p2p_port_i ? ADDR_P2P : slave_addr_i; // [RULE22]
   // Silence alone delimits frames; no byte value is special [RULE9] [RULE21]
   assign gap_hit = (s_q.idle >= gap_cyc);
   assign load    = !s_q.tx_valid || tx_ready_i;
   assign fifo_pop = (s_q.st == TX_BODY) && load;
   assign flush    = s_q.drop;
   // Reply bytes are refused unless a request is awaiting its answer [RULE2]
   assign reply_ready_o = fifo_in_rdy && s_q.pend && (s_q.st != TX_IDLE);

   mrs_fifo #(
      .WIDTH ($bits(mrs_byte_t)),
      .DEPTH (DEPTH)
   ) mrs_fifo_i (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .flush_i     (flush),
      .in_valid_i  (reply_valid_i && s_q.pend && (s_q.st != TX_IDLE)),
      .in_data_i   (reply_data_i),
      .in_ready_o  (fifo_in_rdy),
      .out_valid_o (fifo_v),
      .out_data_o  (fifo_out),
      .out_ready_i (fifo_pop)
   );

   always_comb begin
      logic        addr_ok;
      addr_ok = 1'b0;
      s_d = s_q;
      s_d.out_valid = 1'b0;
      s_d.done      = 1'b0;
      s_d.drop      = 1'b0;
      if (s_q.idle != '1) begin
         s_d.idle = s_q.idle + 1'b1;
      end
      // Gap after collected bytes closes the frame and issues a verdict [RULE11]
      if (s_q.in_frame && (s_q.idle == gap_cyc)) begin
         addr_ok = ((s_q.addr == own_addr) && (own_addr != ADDR_BCAST) &&
                    (own_addr <= ADDR_MAX)) || (s_q.addr == ADDR_BCAST);
         s_d.in_frame          = 1'b0;
         s_d.done              = 1'b1;
         s_d.verdict.bcast     = (s_q.addr == ADDR_BCAST); // [RULE5]
         // Residue is zero over a good frame with its check bytes [RULE25] [RULE3]
         s_d.verdict.crc_bad   = (s_q.rx_crc != CRC_RESIDUE) || (s_q.nbytes < MIN_FRAME);
         s_d.verdict.addr_miss = !addr_ok || master_mode_i; // [RULE24] [RULE26]
         // [RULE6] [RULE15] [RULE16] [RULE17] [RULE18] [RULE19]
         s_d.verdict.func_bad  = !mrs_func_ok(s_q.func);
         s_d.verdict.rx_err    = s_q.err;
         s_d.verdict.ok        = !s_d.verdict.crc_bad && !s_d.verdict.addr_miss &&
                                 !s_d.verdict.func_bad && !s_q.err;
         // Only an accepted, addressed request arms a reply [RULE2] [RULE5] [RULE26]
         if (s_d.verdict.ok && !s_d.verdict.bcast && (s_q.st == TX_IDLE)) begin
            s_d.pend = 1'b1;
         end
      end
      if (rx_valid_i) begin
         s_d.idle      = '0;
         s_d.out_valid = 1'b1;
         s_d.out_data  = rx_data_i;
         // After silence, or with none open, the byte starts a new frame [RULE10] [RULE12]
         if (!s_q.in_frame || gap_hit) begin
            s_d.in_frame  = 1'b1;
            s_d.out_first = 1'b1;
            s_d.nbytes    = 8'h01;
            s_d.addr      = rx_data_i;
            s_d.rx_crc    = mrs_crc_step(CRC_INIT, rx_data_i);
            s_d.err       = rx_err_i;
         end else begin
            s_d.out_first = 1'b0;
            if (s_q.nbytes == 8'h01) begin
               s_d.func = rx_data_i; // [RULE6]
            end
            // Data length is free; the count only saturates [RULE7]
            if (s_q.nbytes != 8'hff) begin
               s_d.nbytes = s_q.nbytes + 1'b1;
            end
            s_d.rx_crc = mrs_crc_step(s_q.rx_crc, rx_data_i);
            s_d.err    = s_q.err || rx_err_i;
         end
      end
      if (load) begin
         s_d.tx_valid = 1'b0;
      end
      case (s_q.st)
         TX_IDLE: begin
            s_d.tmo = '0;
            if (s_q.pend) begin
               s_d.st = TX_WAIT;
            end
         end
         TX_WAIT: begin
            s_d.tmo = s_q.tmo + 1'b1;
            // Frame end already lies a full gap behind us [RULE20]
            if (fifo_v && load) begin
               s_d.tx_valid = 1'b1;
               s_d.tx_data  = own_addr; // [RULE4]
               s_d.tx_crc   = mrs_crc_step(CRC_INIT, own_addr);
               s_d.st       = TX_BODY;
            end else if (s_q.tmo == CNT_W'(TMO_CYC - 1)) begin
               // No answer within a scan cycle: give the request up [RULE20]
               s_d.pend = 1'b0;
               s_d.drop = 1'b1;
               s_d.st   = TX_IDLE;
            end
         end
         TX_BODY: begin
            // No timeout here: the user side owns the pace of the body
            if (fifo_v && load) begin
               s_d.tx_valid = 1'b1;
               s_d.tx_data  = fifo_out.data;
               s_d.tx_crc   = mrs_crc_step(s_q.tx_crc, fifo_out.data);
               if (fifo_out.last) begin
                  s_d.st = TX_CRC_LO;
               end
            end
         end
         TX_CRC_LO: begin
            if (load) begin
               s_d.tx_valid = 1'b1;
               s_d.tx_data  = s_q.tx_crc[7:0]; // [RULE8]
               s_d.st       = TX_CRC_HI;
            end
         end
         TX_CRC_HI: begin
            if (load) begin
               s_d.tx_valid = 1'b1;
               s_d.tx_data  = s_q.tx_crc[15:8]; // [RULE8]
               s_d.pend     = 1'b0;
               s_d.st       = TX_IDLE;
            end
         end
         default: begin
            s_d.st = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_q      <= '0;
         s_q.idle <= '1;
         s_q.st   <= TX_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_valid_o  = s_q.out_valid;
   assign out_data_o   = s_q.out_data;
   assign out_first_o  = s_q.out_first;
   assign frame_done_o = s_q.done;
   assign verdict_o    = s_q.verdict;
   assign reply_drop_o = s_q.drop;
   // The transmitter only ever carries replies built here [RULE1]
   assign tx_valid_o   = s_q.tx_valid;
   assign tx_data_o    = s_q.tx_data;
   assign tx_busy_o    = (s_q.st != TX_IDLE) || s_q.tx_valid;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_first_after_gap;
      rx_valid_i && (!s_q.in_frame || gap_hit) |=> out_valid_o && out_first_o && s_q.nbytes == 8'h01;
   endproperty
   a_first_after_gap: assert property (p_first_after_gap) else $error("new frame not started"); // [RULE10]

   property p_done_on_gap;
      s_q.in_frame && s_q.idle == gap_cyc |=> frame_done_o ##1 !frame_done_o;
   endproperty
   a_done_on_gap: assert property (p_done_on_gap) else $error("frame not closed at gap"); // [RULE11]

   property p_reply_needs_request;
      $rose(tx_valid_o) |-> $past(s_q.pend) &&
         ($past(s_q.st) == TX_WAIT || $past(s_q.st) == TX_BODY);
   endproperty
   a_reply_needs_request: assert property (p_reply_needs_request) else $error("unasked reply"); // [RULE2]

   property p_addr_first;
      s_q.st == TX_WAIT && fifo_v && load |=> tx_valid_o && tx_data_o == $past(own_addr);
   endproperty
   a_addr_first: assert property (p_addr_first) else $error("reply not led by own address"); // [RULE4]

   property p_bcast_silent;
      frame_done_o && verdict_o.bcast && $past(s_q.st) == TX_IDLE |-> !s_q.pend;
   endproperty
   a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast armed a reply"); // [RULE5]

   property p_crc_order;
      s_q.st == TX_CRC_LO && load |=> tx_data_o == $past(s_q.tx_crc[7:0]) ##1 s_q.st != TX_CRC_LO;
   endproperty
   a_crc_order: assert property (p_crc_order) else $error("check bytes out of order"); // [RULE8]

   property p_gap_floor;
      sel >= BAUD_SEL_FLOOR |-> gap_cyc == CNT_W'(GAP_CYC[BAUD_SEL_FLOOR]);
   endproperty
   a_gap_floor: assert property (p_gap_floor) else $error("gap below floor value"); // [RULE13]

   property p_bad_discard;
      frame_done_o && !verdict_o.ok && $past(s_q.st) == TX_IDLE && !$past(s_q.pend) |-> !s_q.pend;
   endproperty
   a_bad_discard: assert property (p_bad_discard) else $error("bad frame armed a reply"); // [RULE26]

   property p_timeout;
      s_q.st == TX_WAIT && s_q.tmo == CNT_W'(TMO_CYC - 1) && !(fifo_v && load)
         |=> reply_drop_o && s_q.st == TX_IDLE && !s_q.pend;
   endproperty
   a_timeout: assert property (p_timeout) else $error("reply wait not bounded"); // [RULE20]

   property p_p2p_addr;
      p2p_port_i |-> own_addr == ADDR_P2P;
   endproperty
   a_p2p_addr: assert property (p_p2p_addr) else $error("point-to-point address not 1"); // [RULE22]

   property p_master_deaf;
      frame_done_o && $past(master_mode_i) |-> !verdict_o.ok;
   endproperty
   a_master_deaf: assert property (p_master_deaf) else $error("master mode accepted a frame"); // [RULE24]

   c_good_frame: cover property (frame_done_o && verdict_o.ok && !verdict_o.bcast);
   c_bcast:      cover property (frame_done_o && verdict_o.ok && verdict_o.bcast);
   c_reply_end:  cover property (s_q.st == TX_CRC_HI && load);
   c_drop:       cover property (reply_drop_o);
endmodule

`default_nettype wire

/* File: hdl/mrs_pkg.sv */
/*
 Shared constants, carrier types and helpers of the serial-line slave framer.
 Assumes one 250 MHz system clock; all times below are converted to cycles of it.
*/
package mrs_pkg;

   localparam int unsigned CLK_PERIOD_NS = 4;

   // Frame gap (3.5 characters of 11 bits) per line rate, in ns
   localparam int unsigned GAP_NS_1200  = 32083000;
   localparam int unsigned GAP_NS_2400  = 16042000;
   localparam int unsigned GAP_NS_4800  = 8021000;
   localparam int unsigned GAP_NS_9600  = 4010000;
   localparam int unsigned GAP_NS_19200 = 2005000;

   // Least times, so rounded up
   localparam int unsigned GAP_CYC_1200  = (GAP_NS_1200 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CYC_2400  = (GAP_NS_2400 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CYC_4800  = (GAP_NS_4800 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CYC_9600  = (GAP_NS_9600 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CYC_19200 = (GAP_NS_19200 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Reply timeout standing in for one equipment scan cycle
   localparam int unsigned REPLY_TMO_NS  = 100000000;
   localparam int unsigned REPLY_TMO_CYC = REPLY_TMO_NS / CLK_PERIOD_NS;

   localparam int unsigned CNT_W      = 25;
   localparam int unsigned FIFO_DEPTH = 8;

   localparam logic [2:0] BAUD_SEL_FLOOR   = 3'h4;
   localparam logic [2:0] BAUD_SEL_MAX     = 3'h6;
   localparam logic [2:0] BAUD_SEL_DEFAULT = 3'h4;

   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] ADDR_P2P   = 8'h01;
   localparam logic [7:0] ADDR_MAX   = 8'hf7;

   localparam logic [7:0] FC_RD_COILS     = 8'h01;
   localparam logic [7:0] FC_RD_DISCRETE  = 8'h02;
   localparam logic [7:0] FC_RD_HOLDING   = 8'h03;
   localparam logic [7:0] FC_RD_INPUT     = 8'h04;
   localparam logic [7:0] FC_WR_COIL      = 8'h05;
   localparam logic [7:0] FC_WR_REG       = 8'h06;
   localparam logic [7:0] FC_WR_COILS     = 8'h0f;
   localparam logic [7:0] FC_WR_REGS      = 8'h10;
   localparam logic [7:0] FC_DEVICE_IDENT = 8'h2b;

   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'ha001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   localparam logic [7:0]  MIN_FRAME   = 8'h04;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } mrs_byte_t;

   typedef struct packed {
      logic ok;
      logic bcast;
      logic crc_bad;
      logic addr_miss;
      logic func_bad;
      logic rx_err;
   } mrs_verdict_t;

   typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_BODY, TX_CRC_LO, TX_CRC_HI} mrs_tx_st_t;

   function automatic logic [15:0] mrs_crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic mrs_func_ok(input logic [7:0] f);
      return (f == FC_RD_COILS) || (f == FC_RD_DISCRETE) || (f == FC_RD_HOLDING) ||
             (f == FC_RD_INPUT) || (f == FC_WR_COIL) || (f == FC_WR_REG) ||
             (f == FC_WR_COILS) || (f == FC_WR_REGS) || (f == FC_DEVICE_IDENT);
   endfunction

endpackage

/* File: tb/mrs_master_model.sv */
/*
 Behavioural bus master facing the framer: sends request bytes as strobes and
 takes reply bytes. Assumes the testbench sequences frames and silences.
*/
`timescale 1ns/1ps
`default_nettype none

module mrs_master_model (
   input  wire logic       ref_clk_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   output logic            rx_err_o
);
   logic [7:0] seen_q [$];
   bit         stall = 1'b0;
   bit         slow  = 1'b0;
   bit         tog   = 1'b0;

   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
      rx_err_o   = 1'b0;
      tx_ready_o = 1'b0;
   end

   // Only this side opens an exchange, one raw byte per strobe
   task automatic send(input logic [7:0] b, input logic err);
      @(posedge ref_clk_i);
      #1;
      rx_valid_o = 1'b1;
      rx_data_o  = b;
      rx_err_o   = err;
      @(posedge ref_clk_i);
      #1;
      rx_valid_o = 1'b0;
      // Data is meaningless between strobes, so show something wrong
      rx_data_o  = ~b;
      rx_err_o   = 1'b0;
   endtask

   // Slow mode accepts every other cycle; stall accepts nothing
   always @(posedge ref_clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         seen_q.push_back(tx_data_i);
      end
      tog <= ~tog;
      tx_ready_o <= #1 !stall && (!slow || tog);
   end
endmodule

`default_nettype wire

/* File: tb/mrs_framer_tb.sv */
/*
 Self-checking bench of the framer: requests, verdicts, replies, gaps.
 Assumes mrs_pkg, mrs_framer and the master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module mrs_framer_tb;
   import mrs_pkg::*;
   localparam int unsigned GC [5] = '{80, 60, 40, 30, 20};
   logic         clk = 1'b0;
   logic         rst_i = 1'b1;
   logic [2:0]   baud_sel = 3'h4;
   logic [7:0]   slave_addr = 8'h05;
   logic         p2p = 1'b0;
   logic         master_mode = 1'b0;
   logic         reply_valid = 1'b0;
   mrs_byte_t    reply_data = '0;
   logic         rx_valid, rx_err, tx_ready, out_valid, out_first, frame_done;
   logic         reply_ready, reply_drop, tx_valid, tx_busy;
   logic [7:0]   rx_data, tx_data, out_data;
   mrs_verdict_t verdict;
   int           failures = 0;
   int           n_tests = 0;
   int           n;
   logic [7:0]   na [5] = '{8'h09, 8'h05, 8'h05, 8'h05, 8'h00};
   logic [7:0]   nf [5] = '{8'h03, 8'h03, 8'h07, 8'h03, 8'h03};
   bit           nb [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   int           ne [5] = '{-1, -1, -1, 2, -1};
   logic [5:0]   nv [5] = '{6'h04, 6'h08, 6'h02, 6'h01, 6'h30};
   logic [7:0]   fcs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h2b};

   mrs_framer #(.GAP_CYC(GC), .TMO_CYC(200), .DEPTH(8)) mrs_framer_i (
      .ref_clk_i(clk), .rst_i(rst_i), .baud_sel_i(baud_sel), .slave_addr_i(slave_addr),
      .p2p_port_i(p2p), .master_mode_i(master_mode), .rx_valid_i(rx_valid),
      .rx_data_i(rx_data), .rx_err_i(rx_err), .out_valid_o(out_valid), .out_data_o(out_data),
      .out_first_o(out_first), .frame_done_o(frame_done), .verdict_o(verdict),
      .reply_valid_i(reply_valid), .reply_data_i(reply_data), .reply_ready_o(reply_ready),
      .reply_drop_o(reply_drop), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
      .tx_ready_i(tx_ready), .tx_busy_o(tx_busy));

   mrs_master_model mrs_master_model_i (
      .ref_clk_i(clk), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_err_o(rx_err));

   initial forever #2 clk = ~clk;

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [15:0] crc16(input logic [7:0] q [$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[k]) begin
         c ^= {8'h00, q[k]};
         for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction

   // Request: address, function, two data bytes, check low then high
   task automatic send_frame(input logic [7:0] a, input logic [7:0] fc, input bit bad,
                             input int err_at, input int gap);
      logic [7:0]  q [$];
      logic [15:0] c;
      q = '{a, fc, 8'h00, 8'h2a};
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8] ^ {8{bad}});
      foreach (q[k]) begin
         repeat (k ? gap : 0) @(posedge clk);
         mrs_master_model_i.send(q[k], k == err_at);
         check("echo", {out_valid, out_first, out_data}, {1'b1, k == 0, q[k]});
      end
   endtask

   task automatic wait_done();
      n = 0;
      while (frame_done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("done", frame_done, 1'b1);
   endtask

   task automatic push(input logic [7:0] b, input logic l, output bit took);
      int w;
      w = 0;
      reply_valid = 1'b1;
      reply_data = '{data: b, last: l};
      while (reply_ready !== 1'b1 && w < 20) begin
         @(posedge clk);
         #1;
         w++;
      end
      took = (reply_ready === 1'b1);
      if (took) begin
         @(posedge clk);
         #1;
      end
   endtask

   // Feeds function and data, then compares the whole transmitted frame
   task automatic do_reply(input logic [7:0] own, input logic [7:0] fc, input int nd,
                           input bit stall);
      logic [7:0]  q [$];
      logic [15:0] c;
      int          acc;
      bit          took;
      q = '{own, fc};
      for (int i = 0; i < nd; i++) q.push_back(8'h30 + 8'(i));
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      check("early_tx", tx_valid, 1'b0);
      mrs_master_model_i.seen_q.delete();
      mrs_master_model_i.stall = stall;
      acc = 0;
      for (int i = 1; i <= nd + 1; i++) begin
         push(q[i], i == nd + 1, took);
         if (!took) begin
            check("fifo_fill", acc, 8);
            mrs_master_model_i.stall = 1'b0;
            push(q[i], i == nd + 1, took);
         end
         acc++;
      end
      reply_valid = 1'b0;
      n = 0;
      while (tx_busy !== 1'b0 && n < 500) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("tx_len", mrs_master_model_i.seen_q.size(), q.size());
      foreach (q[k]) check("tx_byte", mrs_master_model_i.seen_q[k], q[k]);
   endtask

   task automatic t_reset();
      check("idle", {out_valid, frame_done, verdict, tx_valid, tx_busy, reply_ready}, 0);
      $display("done: reset");
   endtask

   task automatic t_funcs();
      foreach (fcs[i]) begin
         send_frame(8'h05, fcs[i], 1'b0, -1, 0);
         wait_done();
         check("close", n, GC[4] + 1);
         check("verdict", verdict, 6'h20);
         do_reply(8'h05, fcs[i], 1, 1'b0);
      end
      $display("done: funcs");
   endtask

   task automatic t_fifo();
      mrs_master_model_i.slow = 1'b1;
      send_frame(8'h05, 8'h03, 1'b0, -1, 0);
      wait_done();
      do_reply(8'h05, 8'h03, 9, 1'b1);
      mrs_master_model_i.slow = 1'b0;
      $display("done: fifo");
   endtask

   task automatic t_neg();
      foreach (na[i]) begin
         mrs_master_model_i.seen_q.delete();
         send_frame(na[i], nf[i], nb[i], ne[i], 0);
         wait_done();
         check("verdict", verdict, nv[i]);
         repeat (30) @(posedge clk);
         #1;
         check("silent_rdy", reply_ready, 1'b0);
         check("silent_tx", mrs_master_model_i.seen_q.size(), 0);
      end
      $display("done: neg");
   endtask

   task automatic t_gap();
      mrs_master_model_i.send(8'h05, 1'b0);
      mrs_master_model_i.send(8'h03, 1'b0);
      wait_done();
      check("split", verdict, 6'h08);
      send_frame(8'h00, 8'h03, 1'b0, -1, GC[4] - 6);
      wait_done();
      check("joined", verdict, 6'h30);
      $display("done: gap");
   endtask

   task automatic t_baud();
      for (int s = 0; s < 8; s++) begin
         baud_sel = 3'(s);
         send_frame(8'h00, 8'h01, 1'b0, -1, 0);
         wait_done();
         check("gap", n, GC[s > 4 ? 4 : s] + 1);
      end
      baud_sel = 3'h4;
      $display("done: baud");
   endtask

   task automatic t_addr();
      p2p = 1'b1;
      send_frame(8'h01, 8'h06, 1'b0, -1, 0);
      wait_done();
      check("p2p_hit", verdict, 6'h20);
      do_reply(8'h01, 8'h06, 2, 1'b0);
      send_frame(8'h05, 8'h06, 1'b0, -1, 0);
      wait_done();
      check("p2p_miss", verdict, 6'h04);
      p2p = 1'b0;
      master_mode = 1'b1;
      send_frame(8'h05, 8'h03, 1'b0, -1, 0);
      wait_done();
      check("master", verdict.ok, 1'b0);
      master_mode = 1'b0;
      slave_addr = 8'hf8;
      send_frame(8'hf8, 8'h03, 1'b0, -1, 0);
      wait_done();
      check("range", verdict, 6'h04);
      slave_addr = 8'h05;
      $display("done: addr");
   endtask

   task automatic t_drop();
      mrs_master_model_i.seen_q.delete();
      send_frame(8'h05, 8'h04, 1'b0, -1, 0);
      wait_done();
      n = 0;
      while (reply_drop !== 1'b1 && n < 260) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("drop", reply_drop, 1'b1);
      check("drop_at", n, 201);
      check("drop_tx", mrs_master_model_i.seen_q.size(), 0);
      $display("done: drop");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      #1 rst_i = 1'b0;
      t_reset();
      t_funcs();
      t_fifo();
      t_neg();
      t_gap();
      t_baud();
      t_addr();
      t_drop();
      results();
   end

   // Whole run needs well under 15000 cycles
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      results();
   end
endmodule

`default_nettype wire
